// >>> common/dbg_defines.svh
// offsets, field positions, reset values and timing counts of the debug halt control unit
`ifndef DBG_DEFINES_SVH
`define DBG_DEFINES_SVH

// apb register byte addresses
`define DBG_ADDR_CTRL      12'h000
`define DBG_ADDR_STATUS    12'h004
`define DBG_ADDR_COUNTER   12'h008
`define DBG_ADDR_EXEC      12'h00c
`define DBG_ADDR_W         12

// control register fields
`define DBG_CTRL_HALT_BIT  0
`define DBG_CTRL_BRK_EN    1
`define DBG_CTRL_LOOP_EN   2
`define DBG_CTRL_MODE_LO   3
`define DBG_CTRL_MODE_HI   4

// status register fields
`define DBG_STAT_HALTED    0
`define DBG_STAT_IDLE      1
`define DBG_STAT_STOP      2
`define DBG_STAT_PIN_ENTRY 3
`define DBG_STAT_REJECT    4

// reset values
`define DBG_CTRL_RESET     5'h00
`define DBG_COUNT_RESET    16'h0000

// break opcode, equal to a fully programmed flash byte
`define DBG_BREAK_OPCODE   8'h00

// edge after reset release at which the debug pin is judged: synchroniser latency plus one
`define DBG_PIN_SETTLE     3'h5

`endif

// >>> common/dbg_pkg.sv
// types shared by the debug halt control unit
package dbg_pkg;

   // halt controller states
   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_LOOP = 2'b01,
      ST_HALT = 2'b10
   } dbg_state_e;

   // debug counter use
   typedef enum logic [1:0] {
      CNT_OFF   = 2'b00,
      CNT_CYCLE = 2'b01,
      CNT_ZERO  = 2'b10,
      CNT_MATCH = 2'b11
   } cnt_mode_e;

   // software control fields
   typedef struct packed {
      cnt_mode_e mode;
      logic      loop_en;
      logic      brk_en;
      logic      halt;
   } ctrl_s;

   // instruction seen by the core decoder
   typedef struct packed {
      logic        valid;
      logic [7:0]  opcode;
      logic [15:0] pc;
   } core_fetch_s;

   // instruction the debugger hands to the halted core
   typedef struct packed {
      logic       req;
      logic [7:0] opcode;
   } exec_s;

endpackage

// >>> core/pin_sync.sv
// three-stage synchroniser for an asynchronous pin, change taken when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   input  wire logic clk_sys_i,
   input  wire logic resetn_i,
   input  wire logic pin_i,
   output logic      level_o
);

   logic [2:0] stage;
   logic [2:0] next_stage;
   logic       next_level;

   // shift the pin in, update the level only on agreement of the later stages
   always_comb
   begin
      next_stage = {stage[1:0], pin_i};
      next_level = (stage[2] == stage[1]) ? stage[2] : level_o;
   end

   // register the stages and the filtered level
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         stage   <= {3{RESET_LEVEL}};
         level_o <= RESET_LEVEL;
      end
      else
      begin
         stage   <= next_stage;
         level_o <= next_level;
      end
   end

endmodule

// >>> core/debug_counter.sv
// multipurpose debug counter: cycle count, break at zero, break on program counter match
`timescale 1ns/1ps
`include "dbg_defines.svh"
module debug_counter #(
   parameter int WIDTH = 16
) (
   input  wire logic              clk_sys_i,
   input  wire logic              resetn_i,
   input  wire dbg_pkg::cnt_mode_e mode_i,
   input  wire logic              run_i,
   input  wire logic              load_i,
   input  wire logic [WIDTH-1:0]  load_val_i,
   input  wire logic              pc_valid_i,
   input  wire logic [WIDTH-1:0]  pc_i,
   output logic [WIDTH-1:0]       count_o,
   output logic                   hit_o
);
   import dbg_pkg::*;

   logic [WIDTH-1:0] next_count;
   logic             next_hit;

   // counts only while the core runs, so it freezes on debug entry [R20]
   always_comb
   begin
      next_count = count_o;
      next_hit   = 1'b0;
      if (load_i)
         next_count = load_val_i;
      else if (run_i)
      begin
         case (mode_i)
            CNT_CYCLE: next_count = count_o + WIDTH'(1);     // cycles between breaks [R19]
            CNT_ZERO:
            begin
               if (count_o != '0)
                  next_count = count_o - WIDTH'(1);
               next_hit = (count_o == {{(WIDTH-1){1'b0}}, 1'b1}); // reaching zero [R09]
            end
            CNT_MATCH: next_hit = pc_valid_i && (pc_i == count_o); // address match [R08]
            default:   next_count = count_o;
         endcase
      end
   end

   // register count and hit pulse
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         count_o <= `DBG_COUNT_RESET;
         hit_o   <= 1'b0;
      end
      else
      begin
         count_o <= next_count;
         hit_o   <= next_hit;
      end
   end

endmodule

// >>> core/debug_halt_ctrl.sv
// on-chip debug unit halt control with apb register access
//
// Functional notes
// (R01) halted core stops fetching, runs debugger instructions only
// (R02) system clock keeps running unless stopped
// (R03) peripherals keep running unless stopped
// (R04) debug entry ends halt low-power state
// (R05) watchdog refreshed continuously while halted
// (R06) writing halt bit one enters debug mode
// (R07) enabled break instruction enters debug mode
// (R08) counter match with program counter enters debug
// (R09) counter decrementing to zero enters debug
// (R10) low debug pin at reset release halts
// (R11) clearing halt bit or power-on reset exits
// (R12) disabled breaks run as no operation
// (R13) enabled break halts or loops serving interrupts
// (R14) idle flag shows break looping
// (R15) host clears loop bit to stop looping
// (R16) loop end on returning break sets halt
// (R17) most commands rejected while looping
// (R18) break opcode is 00h
// (R19) sixteen-bit counter with three uses
// (R20) counter runs outside debug mode only
// (R21) halt bit reads back debug mode state
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "dbg_defines.svh"
module debug_halt_ctrl #(
   parameter int CNT_WIDTH = 16
) (
   input  wire logic                   clk_sys_i,
   input  wire logic                   resetn_i,
   // apb slave
   input  wire logic                   psel_i,
   input  wire logic                   penable_i,
   input  wire logic                   pwrite_i,
   input  wire logic [11:0]            paddr_i,
   input  wire logic [31:0]            pwdata_i,
   output logic [31:0]                 prdata_o,
   output logic                        pready_o,
   output logic                        pslverr_o,
   // debug entry pin, asynchronous
   input  wire logic                   debug_entry_pin_i,
   // core side
   input  wire dbg_pkg::core_fetch_s   fetch_i,
   input  wire logic                   stop_mode_i,
   input  wire logic                   halt_mode_i,
   input  wire logic                   wdt_enable_i,
   output logic                        fetch_stop_o,
   output dbg_pkg::exec_s              exec_o,
   output logic                        break_nop_o,
   output logic                        break_loop_o,
   output logic                        halt_exit_o,
   output logic                        clk_run_o,
   output logic                        periph_run_o,
   output logic                        periph_debug_o,
   output logic                        wdt_refresh_o
);
   import dbg_pkg::*;

   // state and control registers
   dbg_state_e          state;
   dbg_state_e          next_state;
   ctrl_s               ctrl;
   ctrl_s               next_ctrl;
   logic [15:0]         loop_pc;
   logic [15:0]         next_loop_pc;
   logic [2:0]          settle;
   logic [2:0]          next_settle;
   logic                pin_entry;
   logic                next_pin_entry;
   logic                reject;
   logic                next_reject;

   // apb answer registers
   logic [31:0]         next_prdata;
   logic                next_pready;
   logic                next_pslverr;

   // outward registered signals
   logic                next_fetch_stop;
   exec_s               next_exec;
   logic                next_break_nop;
   logic                next_break_loop;
   logic                next_halt_exit;
   logic                next_clk_run;
   logic                next_periph_run;
   logic                next_periph_debug;
   logic                next_wdt_refresh;

   // helpers
   logic                pin_level;
   logic                wr_fire;
   logic                setup;
   logic                addr_ok;
   logic                is_break;
   logic                cnt_hit;
   logic [CNT_WIDTH-1:0] cnt_value;
   logic                cnt_load;
   logic                cnt_run;
   logic                halted;
   logic                enter;
   logic                host_exit;

   // debug pin through the three-stage synchroniser, idle high
   pin_sync #(
      .RESET_LEVEL (1'b1)
   ) u_pin_sync (
      .clk_sys_i  (clk_sys_i),
      .resetn_i   (resetn_i),
      .pin_i      (debug_entry_pin_i),
      .level_o    (pin_level)
   );

   // counter steps only while not halted [R20]
   debug_counter #(
      .WIDTH (CNT_WIDTH)
   ) u_counter (
      .clk_sys_i  (clk_sys_i),
      .resetn_i   (resetn_i),
      .mode_i     (ctrl.mode),
      .run_i      (cnt_run),
      .load_i     (cnt_load),
      .load_val_i (pwdata_i[CNT_WIDTH-1:0]),
      .pc_valid_i (fetch_i.valid),
      .pc_i       (fetch_i.pc[CNT_WIDTH-1:0]),
      .count_o    (cnt_value),
      .hit_o      (cnt_hit)
   );

   // bus decode and core break detection
   assign halted   = (state == ST_HALT);
   assign setup    = psel_i && !penable_i;
   assign wr_fire  = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
   assign addr_ok  = (paddr_i == `DBG_ADDR_CTRL) || (paddr_i == `DBG_ADDR_STATUS) ||
                     (paddr_i == `DBG_ADDR_COUNTER) || (paddr_i == `DBG_ADDR_EXEC);
   assign is_break = fetch_i.valid && (fetch_i.opcode == `DBG_BREAK_OPCODE);   // [R18]
   assign cnt_run  = (state != ST_HALT);                                       // [R20]
   // counter writes are a debugger command, taken only when halted [R17]
   assign cnt_load = wr_fire && (paddr_i == `DBG_ADDR_COUNTER) && halted;

   // host halt-bit writes: one enters, zero exits
   assign host_exit = wr_fire && (paddr_i == `DBG_ADDR_CTRL) && !pwdata_i[`DBG_CTRL_HALT_BIT];
   assign enter     = wr_fire && (paddr_i == `DBG_ADDR_CTRL) && pwdata_i[`DBG_CTRL_HALT_BIT]; // [R06]

   // reset-release pin check: wait for the synchroniser, then judge the pin once
   always_comb
   begin
      next_settle    = settle;
      next_pin_entry = pin_entry;
      if (settle != `DBG_PIN_SETTLE)
      begin
         next_settle = settle + 3'h1;
         if ((settle + 3'h1) == `DBG_PIN_SETTLE)
            next_pin_entry = !pin_level;                                          // [R10]
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         settle    <= 3'h0;
         pin_entry <= 1'b0;
      end
      else
      begin
         settle    <= next_settle;
         pin_entry <= next_pin_entry;
      end
   end

   // halt state machine and control register
   always_comb
   begin
      next_state   = state;
      next_ctrl    = ctrl;
      next_loop_pc = loop_pc;
      next_reject  = reject;

      // software control fields
      if (wr_fire && (paddr_i == `DBG_ADDR_CTRL))
      begin
         next_ctrl.brk_en  = pwdata_i[`DBG_CTRL_BRK_EN];
         next_ctrl.loop_en = pwdata_i[`DBG_CTRL_LOOP_EN];
         next_ctrl.mode    = cnt_mode_e'(pwdata_i[`DBG_CTRL_MODE_HI:`DBG_CTRL_MODE_LO]);
      end

      // command acceptance record: rejected while not halted [R17]
      if (wr_fire && ((paddr_i == `DBG_ADDR_EXEC) || (paddr_i == `DBG_ADDR_COUNTER)))
         next_reject = !halted;

      case (state)
         ST_RUN:
         begin
            if (enter || cnt_hit || ((settle + 3'h1) == `DBG_PIN_SETTLE && settle != `DBG_PIN_SETTLE
                                     && !pin_level))                               // [R06] [R08] [R09] [R10]
               next_state = ST_HALT;
            else if (is_break && next_ctrl.brk_en)                               // disabled break is ignored [R12]
            begin
               if (next_ctrl.loop_en)
               begin
                  next_state   = ST_LOOP;                                          // loop, interrupts served [R13]
                  next_loop_pc = fetch_i.pc;
               end
               else
                  next_state = ST_HALT;                                            // [R07] [R13]
            end
         end
         ST_LOOP:
         begin
            if (enter || cnt_hit)
               next_state = ST_HALT;
            else if (!next_ctrl.brk_en)
               next_state = ST_RUN;
            // host drops the loop bit, core comes back to the looping break [R15]
            else if (!next_ctrl.loop_en && is_break && (fetch_i.pc == loop_pc))
               next_state = ST_HALT;                                               // [R16]
         end
         ST_HALT:
         begin
            if (host_exit)
               next_state = ST_RUN;                                                // [R11]
         end
         default: next_state = ST_RUN;
      endcase

      // halt bit mirrors debug mode, whatever the cause [R21]
      next_ctrl.halt = (next_state == ST_HALT);
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state   <= ST_RUN;                                                        // power-on reset exits [R11]
         ctrl    <= ctrl_s'(`DBG_CTRL_RESET);
         loop_pc <= 16'h0000;
         reject  <= 1'b0;
      end
      else
      begin
         state   <= next_state;
         ctrl    <= next_ctrl;
         loop_pc <= next_loop_pc;
         reject  <= next_reject;
      end
   end

   // apb answer: one wait-free access phase, error on unmapped address
   always_comb
   begin
      next_pready  = setup;
      next_pslverr = setup && !addr_ok;
      next_prdata  = 32'h0000_0000;
      if (setup)
      begin
         case (paddr_i)
            `DBG_ADDR_CTRL:
               next_prdata = {27'h0000000, ctrl.mode, ctrl.loop_en, ctrl.brk_en, halted}; // [R21]
            `DBG_ADDR_STATUS:
            begin
               next_prdata[`DBG_STAT_HALTED]    = halted;
               next_prdata[`DBG_STAT_IDLE]      = (state == ST_LOOP);              // [R14]
               next_prdata[`DBG_STAT_STOP]      = stop_mode_i;
               next_prdata[`DBG_STAT_PIN_ENTRY] = pin_entry;
               next_prdata[`DBG_STAT_REJECT]    = reject;
            end
            `DBG_ADDR_COUNTER:
               next_prdata = {{(32-CNT_WIDTH){1'b0}}, cnt_value};
            default:
               next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         prdata_o  <= 32'h0000_0000;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         prdata_o  <= next_prdata;
         pready_o  <= next_pready;
         pslverr_o <= next_pslverr;
      end
   end

   // core, clock, peripheral and watchdog controls
   always_comb
   begin
      next_fetch_stop   = (next_state == ST_HALT);                                 // [R01]
      next_exec.req     = wr_fire && (paddr_i == `DBG_ADDR_EXEC) && halted;        // [R01] [R17]
      next_exec.opcode  = pwdata_i[7:0];
      next_break_nop    = !next_ctrl.brk_en;                                       // [R12]
      next_break_loop   = (next_state == ST_LOOP);                                 // [R13]
      next_halt_exit    = (next_state == ST_HALT) && (state != ST_HALT) && halt_mode_i; // [R04]
      next_clk_run      = !stop_mode_i;                                            // [R02]
      next_periph_run   = !stop_mode_i;                                            // [R03]
      next_periph_debug = (next_state == ST_HALT);                                 // [R03]
      next_wdt_refresh  = (next_state == ST_HALT) && wdt_enable_i;                 // [R05]
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         fetch_stop_o   <= 1'b0;
         exec_o         <= '0;
         break_nop_o    <= 1'b1;
         break_loop_o   <= 1'b0;
         halt_exit_o    <= 1'b0;
         clk_run_o      <= 1'b1;
         periph_run_o   <= 1'b1;
         periph_debug_o <= 1'b0;
         wdt_refresh_o  <= 1'b0;
      end
      else
      begin
         fetch_stop_o   <= next_fetch_stop;
         exec_o         <= next_exec;
         break_nop_o    <= next_break_nop;
         break_loop_o   <= next_break_loop;
         halt_exit_o    <= next_halt_exit;
         clk_run_o      <= next_clk_run;
         periph_run_o   <= next_periph_run;
         periph_debug_o <= next_periph_debug;
         wdt_refresh_o  <= next_wdt_refresh;
      end
   end

endmodule

// >>> tb/debug_halt_ctrl_props.sv
// assertion checker bound to the ports of the debug halt control unit
`timescale 1ns/1ps
`include "dbg_defines.svh"
module debug_halt_ctrl_props #(parameter int CNT_WIDTH = 16) (
   input wire logic                 clk_sys_i,
   input wire logic                 resetn_i,
   input wire logic                 psel_i,
   input wire logic                 penable_i,
   input wire logic                 pwrite_i,
   input wire logic [11:0]          paddr_i,
   input wire logic [31:0]          pwdata_i,
   input wire logic                 pready_o,
   input wire dbg_pkg::core_fetch_s fetch_i,
   input wire logic                 stop_mode_i,
   input wire logic                 wdt_enable_i,
   input wire logic                 fetch_stop_o,
   input wire dbg_pkg::exec_s       exec_o,
   input wire logic                 break_nop_o,
   input wire logic                 break_loop_o,
   input wire logic                 halt_exit_o,
   input wire logic                 clk_run_o,
   input wire logic                 periph_run_o,
   input wire logic                 periph_debug_o,
   input wire logic                 wdt_refresh_o
);
   import dbg_pkg::*;
   // completed control write, and a break fetched while the core runs
   wire ctrl_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == `DBG_ADDR_CTRL;
   wire brk_run = fetch_i.valid && fetch_i.opcode == `DBG_BREAK_OPCODE && !fetch_stop_o && !break_loop_o;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);
   // relations between requests and the halt outputs
   AST_READY: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready");
   AST_ENTRY: assert property (ctrl_wr && pwdata_i[0] |-> ##[1:2] fetch_stop_o) else $error("no entry");
   AST_EXIT: assert property (ctrl_wr && !pwdata_i[0] |-> ##[1:2] !fetch_stop_o) else $error("no exit");
   AST_BREAK: assert property (brk_run && !break_nop_o |=> fetch_stop_o || break_loop_o) else $error("brk");
   AST_NOP: assert property (brk_run && break_nop_o && !psel_i && !$past(psel_i) |=> !fetch_stop_o)
      else $error("nop halted");
   AST_CLK: assert property (clk_run_o == !$past(stop_mode_i)) else $error("clock run");
   AST_PERIPH: assert property (periph_run_o == clk_run_o && periph_debug_o == fetch_stop_o)
      else $error("peripheral run");
   AST_WDT: assert property (fetch_stop_o && $past(fetch_stop_o) && wdt_enable_i && $past(wdt_enable_i)
      |-> wdt_refresh_o) else $error("no refresh");
   AST_HALT_EXIT: assert property (halt_exit_o |-> ##[0:1] fetch_stop_o) else $error("halt exit");
   AST_EXEC: assert property (exec_o.req |-> fetch_stop_o) else $error("exec while running");
endmodule
bind debug_halt_ctrl debug_halt_ctrl_props #(.CNT_WIDTH(CNT_WIDTH)) u_props (.clk_sys_i, .resetn_i, .psel_i,
   .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .fetch_i, .stop_mode_i, .wdt_enable_i, .fetch_stop_o,
   .exec_o, .break_nop_o, .break_loop_o, .halt_exit_o, .clk_run_o, .periph_run_o, .periph_debug_o, .wdt_refresh_o);

// >>> tb/debug_host_model.sv
// host debugger model: apb master reaching the debug unit registers
`timescale 1ns/1ps
module debug_host_model (
   input  wire logic        clk_sys_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [11:0]      paddr_o,
   output logic [31:0]      pwdata_o,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i
);
   // bus idle at time zero
   initial
   begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 12'h000;
      pwdata_o = 32'h0;
   end
   // setup, access held until ready, then release with scrambled lines
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
             output logic err, output logic ok);
      int i;
      ok = 1'b0;
      @(posedge clk_sys_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= wd;
      @(posedge clk_sys_i);
      penable_o <= 1'b1;
      for (i = 0; i < 16 && !ok; i++)
      begin
         @(posedge clk_sys_i);
         ok = (pready_i === 1'b1);
      end
      rd = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      paddr_o <= ~a;
      pwdata_o <= ~wd;
   endtask
endmodule

// >>> tb/debug_halt_ctrl_tb.sv
// self-checking bench for the debug halt control unit
`timescale 1ns/1ps
`include "dbg_defines.svh"
module debug_halt_ctrl_tb;
   import dbg_pkg::*;
   logic        clk_sys_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, debug_entry_pin_i;
   logic        stop_mode_i, halt_mode_i, wdt_enable_i, fetch_stop_o, break_nop_o, break_loop_o, halt_exit_o;
   logic        clk_run_o, periph_run_o, periph_debug_o, wdt_refresh_o, seen, err, ok;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, v1, v2;
   logic [8:0]  ex;
   core_fetch_s fetch_i;
   exec_s       exec_o;
   int          num_errors = 0;
   int          cmp_count = 0;
   // design and host model
   debug_halt_ctrl u_debug_halt_ctrl (.clk_sys_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .debug_entry_pin_i, .fetch_i, .stop_mode_i, .halt_mode_i, .wdt_enable_i,
      .fetch_stop_o, .exec_o, .break_nop_o, .break_loop_o, .halt_exit_o, .clk_run_o, .periph_run_o,
      .periph_debug_o, .wdt_refresh_o);
   debug_host_model u_debug_host_model (.clk_sys_i, .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
      .paddr_o(paddr_i), .pwdata_o(pwdata_i), .prdata_i(prdata_o), .pready_i(pready_o), .pslverr_i(pslverr_o));
   // clock
   initial
   begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   // verdict and end of run
   task complete_run;
      if (num_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask
   // one apb transfer, a hang ends the run
   task acc(input logic w, input logic [11:0] a, input logic [31:0] wd);
      u_debug_host_model.xfer(w, a, wd, v2, err, ok);
      if (ok !== 1'b1)
      begin
         num_errors++;
         complete_run;
      end
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0);
      chk(v2, exp);
   endtask
   // watch outputs for n+1 cycles, keeping pulses
   task watch(input int n);
      seen = 1'b0;
      ex = 9'h000;
      repeat (n + 1)
      begin
         #1;
         seen = seen | halt_exit_o;
         if (exec_o.req === 1'b1)
            ex = {1'b1, exec_o.opcode};
         @(posedge clk_sys_i);
      end
      #1;
   endtask
   task fetch(input logic [7:0] op, input logic [15:0] pc);
      @(posedge clk_sys_i);
      fetch_i <= '{1'b1, op, pc};
      @(posedge clk_sys_i);
      fetch_i <= '0;
   endtask
   // refused access, host halt, exec, exit
   task t_host;
      acc(1'b1, 12'h010, 32'h1);
      chk({30'h0, err, fetch_stop_o}, 32'h2);
      chk(v2, 32'h0);
      @(posedge clk_sys_i);
      halt_mode_i <= 1'b1;
      wdt_enable_i <= 1'b1;
      acc(1'b1, `DBG_ADDR_CTRL, 32'h1);
      watch(3);
      chk({fetch_stop_o, periph_debug_o, wdt_refresh_o, clk_run_o, seen}, 32'h1f);
      stop_mode_i <= 1'b1;
      watch(2);
      chk({clk_run_o, periph_run_o}, 32'h0);
      rdc(`DBG_ADDR_STATUS, 32'h5);
      stop_mode_i <= 1'b0;
      watch(2);
      chk({clk_run_o, periph_run_o, fetch_stop_o}, 32'h7);
      rdc(`DBG_ADDR_CTRL, 32'h1);
      acc(1'b1, `DBG_ADDR_EXEC, 32'h5a);
      watch(3);
      chk(ex, 32'h15a);
      halt_mode_i <= 1'b0;
      acc(1'b1, `DBG_ADDR_CTRL, 32'h0);
      watch(2);
      chk({fetch_stop_o, periph_debug_o, wdt_refresh_o}, 32'h0);
      rdc(`DBG_ADDR_CTRL, 32'h0);
   endtask
   // break disabled, other opcode, break enabled
   task t_brk;
      fetch(8'h00, 16'h0100);
      watch(3);
      chk({fetch_stop_o, break_nop_o}, 32'h1);
      acc(1'b1, `DBG_ADDR_CTRL, 32'h2);
      fetch(8'h01, 16'h0102);
      watch(3);
      chk({fetch_stop_o, break_nop_o}, 32'h0);
      fetch(8'h00, 16'h0104);
      watch(3);
      rdc(`DBG_ADDR_STATUS, 32'h1);
   endtask
   // loop on break, refused command, host clears loop bit, return halts
   task t_loop;
      acc(1'b1, `DBG_ADDR_CTRL, 32'h6);
      fetch(8'h00, 16'h1234);
      watch(3);
      chk({break_loop_o, fetch_stop_o}, 32'h2);
      rdc(`DBG_ADDR_STATUS, 32'h2);
      acc(1'b1, `DBG_ADDR_COUNTER, 32'h5);
      rdc(`DBG_ADDR_STATUS, 32'h12);
      acc(1'b1, `DBG_ADDR_CTRL, 32'h2);
      fetch(8'h00, 16'h1234);
      watch(3);
      chk(fetch_stop_o, 1'b1);
      rdc(`DBG_ADDR_CTRL, 32'h3);
   endtask
   // counter: down to zero, cycle count, program counter match
   task t_count;
      acc(1'b1, `DBG_ADDR_COUNTER, 32'h5);
      rdc(`DBG_ADDR_COUNTER, 32'h5);
      acc(1'b1, `DBG_ADDR_CTRL, 32'h10);
      watch(9);
      chk(fetch_stop_o, 1'b1);
      rdc(`DBG_ADDR_COUNTER, 32'h0);
      acc(1'b1, `DBG_ADDR_CTRL, 32'h9);
      acc(1'b1, `DBG_ADDR_CTRL, 32'h8);
      watch(10);
      acc(1'b1, `DBG_ADDR_CTRL, 32'h9);
      acc(1'b0, `DBG_ADDR_COUNTER, 32'h0);
      v1 = v2;
      watch(5);
      rdc(`DBG_ADDR_COUNTER, v1);
      chk(v1 > 32'd10 && v1 < 32'd20, 32'h1);
      acc(1'b1, `DBG_ADDR_COUNTER, 32'h42);
      acc(1'b1, `DBG_ADDR_CTRL, 32'h18);
      fetch(8'h11, 16'h0041);
      watch(3);
      chk(fetch_stop_o, 1'b0);
      fetch(8'h11, 16'h0042);
      watch(3);
      chk(fetch_stop_o, 1'b1);
      acc(1'b1, `DBG_ADDR_CTRL, 32'h0);
   endtask
   // reset with the entry pin low
   task t_pin;
      @(posedge clk_sys_i);
      debug_entry_pin_i <= 1'b0;
      resetn_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      watch(6);
      rdc(`DBG_ADDR_STATUS, 32'h9);
      debug_entry_pin_i <= 1'b1;
      acc(1'b1, `DBG_ADDR_CTRL, 32'h0);
      watch(2);
      chk(fetch_stop_o, 1'b0);
   endtask
   // main sequence
   initial
   begin
      resetn_i = 1'b0;
      debug_entry_pin_i = 1'b1;
      fetch_i = '0;
      stop_mode_i = 1'b0;
      halt_mode_i = 1'b0;
      wdt_enable_i = 1'b0;
      repeat (2) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      watch(4);
      chk({break_nop_o, clk_run_o, periph_run_o, fetch_stop_o, periph_debug_o}, 32'h1c);
      t_host;
      t_brk;
      acc(1'b1, `DBG_ADDR_CTRL, 32'h0);
      t_loop;
      t_count;
      t_pin;
      complete_run;
   end
endmodule
